// *** core/poc_pkg.sv ***
package poc_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TEND = 8'h04;
  localparam logic [7:0] REG_ADDRESS_SPACE_IDENTIFIER = 8'h08;
  localparam logic [7:0] REG_TIER = 8'h0C;
  localparam logic [7:0] REG_BOUND = 8'h10;
  localparam logic [7:0] REG_FADDR_LO = 8'h14;
  localparam logic [7:0] REG_FADDR_HI = 8'h18;
  localparam logic [7:0] REG_STAT = 8'h1C;

  // control register fields and reset values
  localparam int CTRL_GLOBAL_EN = 0;
  localparam int CTRL_BOUND_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [31:0] TEND_RESET = 32'h0000_0000;

  // error code bit positions
  localparam int ERR_OWNERSHIP = 31;
  localparam int ERR_ENCRYPTED = 34;
  localparam int ERR_SIZE_MISMATCH = 35;
  localparam int ERR_TIER = 36;
  localparam logic [63:0] VALIDATION_CODE = 64'h0000_0000_0000_0404;

  // 4KB constituents of one 2MB page
  localparam int SUB_PAGES = 512;
  localparam int SUB_W = 9;

  // privilege-tier permission mask bits
  localparam int PERM_READ = 0;
  localparam int PERM_WRITE = 1;
  localparam int PERM_XUSER = 2;
  localparam int PERM_XSUPER = 3;

  typedef enum logic [2:0]
  {
    OP_ACCESS = 3'h0,
    OP_SPLIT = 3'h1,
    OP_UPDATE = 3'h2,
    OP_ACCEPT4K = 3'h3,
    OP_ACCEPT2M = 3'h4,
    OP_ADJUST = 3'h5
  } poc_op_t;

  typedef enum logic [1:0]
  {
    ACC_READ = 2'h0,
    ACC_WRITE = 2'h1,
    ACC_FETCH = 2'h2,
    ACC_TABLE = 2'h3
  } poc_acc_t;

  typedef enum logic [1:0]
  {
    MAP_4K = 2'h0,
    MAP_2M = 2'h1,
    MAP_1G = 2'h2
  } poc_map_t;

  typedef enum logic [2:0]
  {
    RES_PASS = 3'h0,
    RES_PAGE_FAULT = 3'h1,
    RES_NESTED_EXIT = 3'h2,
    RES_VALIDATION = 3'h3,
    RES_SIZE_STATUS = 3'h4,
    RES_OP_FAIL = 3'h5
  } poc_res_t;

endpackage

// *** core/poc_checker.sv ***
`timescale 1ns/1ps
module poc_checker
  import poc_pkg::*;
#(
  parameter int IDXW = 32,
  parameter int GPNW = 40,
  parameter int ASIDW = 16
)
(
  input wire logic mclk, // core clock
  input wire logic sys_rst, // async reset, high
  input wire logic [7:0] wb_adr_i, // bus byte address
  input wire logic [31:0] wb_dat_i, // bus write data
  output logic [31:0] wb_dat_o, // bus read data
  input wire logic wb_we_i, // bus write
  input wire logic [3:0] wb_sel_i, // bus byte enables
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  output logic wb_ack_o, // bus acknowledge
  input wire logic reqValid, // request present
  output logic reqReady, // request taken when high
  input wire logic [2:0] reqOp, // operation code
  input wire logic [1:0] reqKind, // kind of access
  input wire logic reqAdUpdate, // accessed or dirty update
  input wire logic reqGuest, // access from a guest
  input wire logic reqProtGuest, // guest is protected
  input wire logic reqPagingOk, // paging checks passed
  input wire logic reqUser, // user level execute
  input wire logic reqEncBit, // encryption bit of translation
  input wire logic [1:0] reqMap, // nested mapping size
  input wire logic [IDXW-1:0] reqIdx, // target entry index
  input wire logic [GPNW-1:0] reqGpa, // guest page number
  input wire logic [63:0] reqGva, // guest virtual address
  input wire logic reqSetVal, // accept op validated value
  input wire logic [3:0] reqPerm, // adjust op new mask
  input wire logic reqAssigned, // update op assigned flag
  input wire logic reqSize, // update op size flag
  input wire logic [ASIDW-1:0] reqAsid, // update op identifier
  output logic rspValid, // result pulse
  output logic [2:0] rspClass, // result class
  output logic [63:0] rspCode, // error code bits
  output logic tblRdReq, // table read pulse
  output logic [IDXW-1:0] tblIdx, // table entry index
  output logic [1:0] tblTier, // tier for mask lookup
  input wire logic tblRdValid, // read data valid
  input wire logic rdAssigned, // entry assigned flag
  input wire logic rdValidated, // entry validated flag
  input wire logic rdImmutable, // entry immutable flag
  input wire logic rdSize, // entry size flag
  input wire logic rdInUse, // entry in use elsewhere
  input wire logic [ASIDW-1:0] rdAsid, // entry identifier
  input wire logic [GPNW-1:0] rdGpa, // entry guest page number
  input wire logic [3:0] rdPerm, // entry mask for tier
  output logic tblWe, // table write pulse
  output logic wrAssigned, // write assigned flag
  output logic wrValidated, // write validated flag
  output logic wrImmutable, // write immutable flag
  output logic wrSize, // write size flag
  output logic [ASIDW-1:0] wrAsid, // write identifier
  output logic [GPNW-1:0] wrGpa, // write guest page number
  output logic [3:0] wrPerm // write mask for tier
);

  if (IDXW < SUB_W + 1 || IDXW > 32 || GPNW < SUB_W || GPNW < 32
      || ASIDW > 32 || ASIDW < 1)
  begin : g_bad
    $error("poc_checker: unsupported parameter values");
  end

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_WAIT = 3'h2,
    ST_EVAL = 3'h3,
    ST_WRITE = 3'h4
  } poc_state_t;

  // ************************************************************
  // register bus
  // ************************************************************
  logic [1:0] ctrl_q;
  logic [31:0] tend_q;
  logic [31:0] address_space_identifier_q;
  logic [1:0] tier_q;
  logic [31:0] bound_q;
  logic [63:0] faddr_q;
  logic wbHit;
  logic wbWr;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWr = wbHit && wb_we_i;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= CTRL_RESET;
      tend_q <= TEND_RESET;
      address_space_identifier_q <= 32'h0000_0000;
      tier_q <= 2'h0;
      bound_q <= 32'h0000_0000;
    end
    else if (wbWr)
    begin
      case (wb_adr_i)
        REG_CTRL: ctrl_q <= wb_sel_i[0] ? wb_dat_i[1:0] : ctrl_q;
        REG_TEND: tend_q <= merge(tend_q, wb_dat_i, wb_sel_i);
        REG_ADDRESS_SPACE_IDENTIFIER: address_space_identifier_q <= merge(address_space_identifier_q, wb_dat_i, wb_sel_i);
        REG_TIER: tier_q <= wb_sel_i[0] ? wb_dat_i[1:0] : tier_q;
        REG_BOUND: bound_q <= merge(bound_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  logic [2:0] lastClass_q;
  logic busy;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wbHit;
      if (wbHit && !wb_we_i)
      begin
        case (wb_adr_i)
          REG_CTRL: wb_dat_o <= {30'h0, ctrl_q};
          REG_TEND: wb_dat_o <= tend_q;
          REG_ADDRESS_SPACE_IDENTIFIER: wb_dat_o <= address_space_identifier_q;
          REG_TIER: wb_dat_o <= {30'h0, tier_q};
          REG_BOUND: wb_dat_o <= bound_q;
          REG_FADDR_LO: wb_dat_o <= faddr_q[31:0];
          REG_FADDR_HI: wb_dat_o <= faddr_q[63:32];
          REG_STAT: wb_dat_o <= {28'h0, busy, lastClass_q};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
      else
      begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ************************************************************
  // request capture and check selection
  // ************************************************************
  poc_state_t state_q;
  poc_op_t op_q;
  logic [IDXW-1:0] base_q;
  logic [SUB_W-1:0] cnt_q;
  logic [SUB_W-1:0] last_q;
  logic [1:0] kind_q;
  logic guest_q;
  logic user_q;
  logic map4k_q;
  logic effEnc_q;
  logic fullChk_q;
  logic hvChk_q;
  logic setVal_q;
  logic [3:0] perm_q;
  logic newAssigned_q;
  logic newSize_q;
  logic [ASIDW-1:0] newAsid_q;
  logic [GPNW-1:0] gpa_q;
  logic [63:0] gva_q;
  logic effEnc;
  logic map4k;
  logic isWrite;
  logic isFetchTbl;
  logic [IDXW-1:0] curIdx;
  logic covered;

  assign isWrite = (reqKind == ACC_WRITE) || reqAdUpdate;
  assign isFetchTbl = (reqKind == ACC_FETCH) || (reqKind == ACC_TABLE);
  // 1GB counts as 2MB; outside the full check, only 4KB or an accessed/dirty update selects a single entry
  assign map4k = (reqMap == MAP_4K) || reqAdUpdate;

  always_comb
  begin
    if (isFetchTbl)
    begin
      effEnc = 1'b1;
    end
    else if (ctrl_q[CTRL_BOUND_EN])
    begin
      effEnc = reqGpa < {{(GPNW-32){1'b0}}, bound_q};
    end
    else
    begin
      effEnc = reqEncBit;
    end
  end

  assign curIdx = base_q + {{(IDXW-SUB_W){1'b0}}, cnt_q};
  assign covered = curIdx < tend_q[IDXW-1:0];
  assign busy = state_q != ST_IDLE;

  // ************************************************************
  // check evaluation per fetched entry
  // ************************************************************
  logic eAssigned_q;
  logic eValidated_q;
  logic eImmutable_q;
  logic eSize_q;
  logic eInUse_q;
  logic eCovered_q;
  logic [ASIDW-1:0] eAsid_q;
  logic [GPNW-1:0] eGpa_q;
  logic [3:0] ePerm_q;
  logic [2:0] evClass;
  logic [63:0] evCode;
  logic faultCls;
  logic permOk;

  always_comb
  begin
    case (kind_q)
      ACC_READ: permOk = ePerm_q[PERM_READ];
      ACC_FETCH: permOk = user_q ? ePerm_q[PERM_XUSER]
                                 : ePerm_q[PERM_XSUPER];
      default: permOk = ePerm_q[PERM_WRITE];
    endcase
  end

  assign faultCls = guest_q;

  always_comb
  begin
    evClass = RES_PASS;
    evCode = 64'h0;
    if (op_q == OP_ACCESS)
    begin
      if (eInUse_q && eCovered_q)
      begin
        evClass = faultCls ? RES_NESTED_EXIT : RES_PAGE_FAULT;
        evCode[ERR_OWNERSHIP] = 1'b1;
      end
      else if (hvChk_q)
      begin
        if (eCovered_q && eAssigned_q)
        begin
          evClass = faultCls ? RES_NESTED_EXIT : RES_PAGE_FAULT;
          evCode[ERR_OWNERSHIP] = 1'b1;
        end
      end
      else if (fullChk_q && (!eCovered_q || !eAssigned_q
               || eAsid_q != address_space_identifier_q[ASIDW-1:0]
               || eGpa_q != gpa_q
               || eImmutable_q
               || eSize_q == map4k_q))
      begin
        evClass = RES_NESTED_EXIT;
        evCode[ERR_OWNERSHIP] = 1'b1;
      end
      else if (!eValidated_q)
      begin
        evClass = RES_VALIDATION;
        evCode = VALIDATION_CODE;
      end
      else if (!permOk)
      begin
        evClass = RES_NESTED_EXIT;
        evCode[ERR_OWNERSHIP] = 1'b1;
        evCode[ERR_TIER] = 1'b1;
      end
      if (evClass == RES_NESTED_EXIT)
      begin
        evCode[ERR_ENCRYPTED] = effEnc_q;
      end
    end
    else if (op_q == OP_ACCEPT4K || op_q == OP_ADJUST)
    begin
      if (!eCovered_q || eInUse_q)
      begin
        evClass = RES_OP_FAIL;
      end
      else if (eSize_q)
      begin
        evClass = RES_NESTED_EXIT;
        evCode[ERR_SIZE_MISMATCH] = 1'b1;
        evCode[ERR_ENCRYPTED] = effEnc_q;
      end
    end
    else if (op_q == OP_ACCEPT2M)
    begin
      if (!eCovered_q || eInUse_q)
      begin
        evClass = RES_OP_FAIL;
      end
      else if (!eSize_q)
      begin
        evClass = RES_SIZE_STATUS;
      end
    end
    else if (!eCovered_q || eInUse_q
             || (op_q == OP_SPLIT && !eSize_q))
    begin
      evClass = RES_OP_FAIL;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_ACCESS;
      base_q <= '0;
      cnt_q <= '0;
      last_q <= '0;
      kind_q <= 2'h0;
      guest_q <= 1'b0;
      user_q <= 1'b0;
      map4k_q <= 1'b1;
      effEnc_q <= 1'b0;
      fullChk_q <= 1'b0;
      hvChk_q <= 1'b0;
      setVal_q <= 1'b0;
      perm_q <= 4'h0;
      newAssigned_q <= 1'b0;
      newSize_q <= 1'b0;
      newAsid_q <= '0;
      gpa_q <= '0;
      gva_q <= 64'h0;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspClass <= RES_PASS;
      rspCode <= 64'h0;
      lastClass_q <= RES_PASS;
      faddr_q <= 64'h0;
      tblRdReq <= 1'b0;
      tblIdx <= '0;
      tblTier <= 2'h0;
      tblWe <= 1'b0;
      eAssigned_q <= 1'b0;
      eValidated_q <= 1'b0;
      eImmutable_q <= 1'b0;
      eSize_q <= 1'b0;
      eInUse_q <= 1'b0;
      eCovered_q <= 1'b0;
      eAsid_q <= '0;
      eGpa_q <= '0;
      ePerm_q <= 4'h0;
      wrAssigned <= 1'b0;
      wrValidated <= 1'b0;
      wrImmutable <= 1'b0;
      wrSize <= 1'b0;
      wrAsid <= '0;
      wrGpa <= '0;
      wrPerm <= 4'h0;
    end
    else
    begin
      rspValid <= 1'b0;
      tblRdReq <= 1'b0;
      tblWe <= 1'b0;
      reqReady <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          reqReady <= 1'b1;
          if (reqValid && reqReady)
          begin
            reqReady <= 1'b0;
            op_q <= poc_op_t'(reqOp);
            kind_q <= isWrite ? ACC_WRITE : reqKind;
            guest_q <= reqGuest;
            user_q <= reqUser;
            map4k_q <= map4k;
            effEnc_q <= reqGuest && effEnc;
            fullChk_q <= reqGuest && reqProtGuest
                         && (isFetchTbl || (isWrite && effEnc));
            hvChk_q <= !(reqGuest && reqProtGuest)
                       || (isWrite && !effEnc);
            setVal_q <= reqSetVal;
            perm_q <= reqPerm;
            newAssigned_q <= reqAssigned;
            newSize_q <= reqSize;
            newAsid_q <= reqAsid;
            gpa_q <= reqGpa;
            gva_q <= reqGva;
            cnt_q <= '0;
            last_q <= '0;
            base_q <= reqIdx;
            state_q <= ST_READ;
            if (reqOp == OP_SPLIT)
            begin
              if (reqIdx[SUB_W-1:0] != '0)
              begin
                rspValid <= 1'b1;
                rspClass <= RES_OP_FAIL;
                rspCode <= 64'h0;
                lastClass_q <= RES_OP_FAIL;
                state_q <= ST_IDLE;
              end
            end
            else if (reqOp == OP_ACCESS)
            begin
              if (!reqPagingOk || !ctrl_q[CTRL_GLOBAL_EN]
                  || (!isWrite && !isFetchTbl)
                  || (reqKind == ACC_FETCH && !isWrite
                      && !(reqGuest && reqProtGuest)))
              begin
                // nothing to check: paging already failed or no check
                rspValid <= 1'b1;
                rspClass <= RES_PASS;
                rspCode <= 64'h0;
                lastClass_q <= RES_PASS;
                state_q <= ST_IDLE;
              end
              else if (!map4k && !(reqGuest && reqProtGuest
                       && (isFetchTbl || (isWrite && effEnc))))
              begin
                base_q <= {reqIdx[IDXW-1:SUB_W], {SUB_W{1'b0}}};
                last_q <= SUB_W'(SUB_PAGES - 1);
              end
            end
          end
        end
        ST_READ:
        begin
          tblIdx <= curIdx;
          tblTier <= tier_q;
          if (covered)
          begin
            tblRdReq <= 1'b1;
            state_q <= ST_WAIT;
          end
          else
          begin
            eCovered_q <= 1'b0;
            eAssigned_q <= 1'b0;
            eInUse_q <= 1'b0;
            state_q <= ST_EVAL;
          end
        end
        ST_WAIT:
        begin
          if (tblRdValid)
          begin
            eCovered_q <= 1'b1;
            eAssigned_q <= rdAssigned;
            eValidated_q <= rdValidated;
            eImmutable_q <= rdImmutable;
            eSize_q <= rdSize;
            eInUse_q <= rdInUse;
            eAsid_q <= rdAsid;
            eGpa_q <= rdGpa;
            ePerm_q <= rdPerm;
            state_q <= ST_EVAL;
          end
        end
        ST_EVAL:
        begin
          if (evClass != RES_PASS || cnt_q == last_q)
          begin
            if (evClass == RES_PASS && op_q != OP_ACCESS
                && op_q != OP_ACCEPT2M)
            begin
              state_q <= ST_WRITE;
              wrAssigned <= eAssigned_q;
              wrValidated <= eValidated_q;
              wrImmutable <= eImmutable_q;
              wrSize <= eSize_q;
              wrAsid <= eAsid_q;
              wrGpa <= eGpa_q;
              wrPerm <= ePerm_q;
              case (op_q)
                OP_SPLIT:
                begin
                  wrSize <= 1'b0;
                  last_q <= SUB_W'(SUB_PAGES - 1);
                end
                OP_UPDATE:
                begin
                  wrAssigned <= newAssigned_q;
                  wrAsid <= newAsid_q;
                  wrGpa <= gpa_q;
                  wrSize <= newSize_q;
                  if (newSize_q != eSize_q)
                  begin
                    wrValidated <= 1'b0;
                  end
                end
                OP_ACCEPT4K: wrValidated <= setVal_q;
                OP_ADJUST: wrPerm <= perm_q;
                default: ;
              endcase
            end
            else
            begin
              // one result for the whole request
              state_q <= ST_IDLE;
              rspValid <= 1'b1;
              rspClass <= evClass;
              rspCode <= evCode;
              lastClass_q <= evClass;
              if (evClass == RES_VALIDATION)
              begin
                faddr_q <= gva_q;
              end
            end
          end
          else
          begin
            cnt_q <= cnt_q + 1'b1;
            state_q <= ST_READ;
          end
        end
        ST_WRITE:
        begin
          tblWe <= 1'b1;
          tblIdx <= curIdx;
          if (op_q == OP_SPLIT)
          begin
            wrGpa <= eGpa_q + {{(GPNW-SUB_W){1'b0}}, cnt_q};
          end
          if (cnt_q == last_q)
          begin
            state_q <= ST_IDLE;
            rspValid <= 1'b1;
            rspClass <= RES_PASS;
            rspCode <= 64'h0;
            lastClass_q <= RES_PASS;
          end
          else
          begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

// *** verif/poc_checker_sva.sv ***
`timescale 1ns/1ps
// ****************************************
// result and table write checks
// ****************************************
module poc_checker_sva
  import poc_pkg::*;
#(
  parameter int IDXW = 32,
  parameter int GPNW = 40
)
(
  input wire logic mclk, // clk
  input wire logic sys_rst, // rst
  input wire logic reqValid, // req
  input wire logic reqReady, // rdy
  input wire logic [2:0] reqOp, // op
  input wire logic rspValid, // rsp
  input wire logic [2:0] rspClass, // class
  input wire logic [63:0] rspCode, // code
  input wire logic tblWe, // wr
  input wire logic [IDXW-1:0] tblIdx, // idx
  input wire logic wrSize, // size
  input wire logic [GPNW-1:0] wrGpa // gpa
);
  logic [2:0] opQ;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      opQ <= 3'h0;
    else if (reqValid && reqReady)
      opQ <= reqOp;
  end
  one_rsp_a: assert property (rspValid |=> !rspValid)
    else $error("result longer than one cycle");
  ready_back_a: assert property (rspValid |-> !reqReady ##1 reqReady)
    else $error("ready not back after result");
  vc_code_a: assert property (rspValid && rspClass == RES_VALIDATION
    |-> rspCode == VALIDATION_CODE) else $error("bad validation code");
  pf_own_a: assert property (rspValid && rspClass == RES_PAGE_FAULT
    |-> rspCode[ERR_OWNERSHIP]) else $error("page fault without bit");
  tier_nest_a: assert property (rspValid && rspCode[ERR_TIER]
    |-> rspClass == RES_NESTED_EXIT) else $error("tier bit off exit");
  size_stat_a: assert property (rspValid && rspClass == RES_SIZE_STATUS
    |-> opQ == OP_ACCEPT2M) else $error("size status from wrong op");
  split_size_a: assert property (tblWe && opQ == OP_SPLIT |-> !wrSize)
    else $error("split wrote large size");
  split_seq_a: assert property (tblWe && $past(tblWe) && opQ == OP_SPLIT
    |-> wrGpa == $past(wrGpa) + 1'b1 && tblIdx == $past(tblIdx) + 1'b1)
    else $error("split not consecutive");
  cover property (rspValid && rspClass == RES_VALIDATION);
  cover property (tblWe && opQ == OP_SPLIT);
  cover property (rspValid && rspClass == RES_SIZE_STATUS);
endmodule

bind poc_checker poc_checker_sva #(.IDXW(IDXW), .GPNW(GPNW)) u_sva
(
  .mclk(mclk), .sys_rst(sys_rst), .reqValid(reqValid),
  .reqReady(reqReady), .reqOp(reqOp), .rspValid(rspValid),
  .rspClass(rspClass), .rspCode(rspCode), .tblWe(tblWe),
  .tblIdx(tblIdx), .wrSize(wrSize), .wrGpa(wrGpa)
);

// *** verif/poc_table_model.sv ***
`timescale 1ns/1ps
// ****************************************
// ownership table model
// ****************************************
module poc_table_model
#(
  parameter int LAT = 3
)
(
  input wire logic mclk, // clk
  input wire logic tblRdReq, // read pulse
  input wire logic [31:0] tblIdx, // index
  input wire logic tblWe, // write pulse
  input wire logic [64:0] wrEnt, // write entry
  output logic tblRdValid, // answer
  output logic [64:0] rdEnt // read entry
);
  logic [64:0] mem [16];
  logic [3:0] ixQ = 4'h0;
  int cnt = 0;
  initial
  begin
    foreach (mem[i])
      mem[i] = '0;
  end
  always @(posedge mclk)
  begin
    if (tblWe)
      mem[tblIdx[3:0]] <= wrEnt;
    if (tblRdReq)
    begin
      ixQ <= tblIdx[3:0];
      cnt <= LAT;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign tblRdValid = (cnt == 1);
  // stale fields are inverted outside the answer cycle
  assign rdEnt = tblRdValid ? mem[ixQ] : ~mem[ixQ];
endmodule

// *** verif/poc_checker_tb_top.sv ***
`timescale 1ns/1ps
// ****************************************
// bench
// ****************************************
module poc_checker_tb_top
  import poc_pkg::*;
;
  localparam logic [63:0] B31 = 64'h8000_0000;
  localparam logic [63:0] B34 = 64'h4_0000_0000;
  localparam logic [63:0] B35 = 64'h8_0000_0000;
  localparam logic [63:0] B36 = 64'h10_0000_0000;
  localparam logic [64:0] OK1 = {5'h18, 16'h0005, 40'h123, 4'hF};
  logic mclk = 1'b0, sys_rst = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0, reqValid = 1'b0, reqGuest = 1'b0, reqEncBit = 1'b0;
  logic reqProtGuest = 1'b0, reqPagingOk = 1'b0, reqAssigned = 1'b1;
  logic reqSize = 1'b1, wb_ack_o, reqReady, rspValid, tblRdReq, tblRdValid;
  logic tblWe, wrA, wrV, wrI, wrS, reqAdUpdate = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, reqIdx = 32'h0, tblIdx;
  logic [2:0] reqOp = 3'h0, rspClass;
  logic [1:0] reqKind = 2'h0, reqMap = 2'h0, tblTier;
  logic [39:0] reqGpa = 40'h123, wrGpa;
  logic [63:0] reqGva = 64'hDEAD_BEEF_0000_1000, rspCode;
  logic [15:0] reqAsid = 16'h0005, wrAsid;
  logic [3:0] wrPerm;
  logic [64:0] rdEnt, wrEnt;
  int err_count = 0, tests_run = 0;
  assign wrEnt = {wrA, wrV, wrI, wrS, 1'b0, wrAsid, wrGpa, wrPerm};
  poc_checker i_dut
  (
    .mclk, .sys_rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i(4'hF), .wb_cyc_i, .wb_stb_i, .wb_ack_o, .reqValid,
    .reqReady, .reqOp, .reqKind, .reqAdUpdate, .reqGuest,
    .reqProtGuest, .reqPagingOk, .reqUser(1'b0), .reqEncBit, .reqMap,
    .reqIdx, .reqGpa, .reqGva, .reqSetVal(1'b1), .reqPerm(4'hF),
    .reqAssigned, .reqSize, .reqAsid, .rspValid, .rspClass, .rspCode,
    .tblRdReq, .tblIdx, .tblTier, .tblRdValid, .rdAssigned(rdEnt[64]),
    .rdValidated(rdEnt[63]), .rdImmutable(rdEnt[62]), .rdSize(rdEnt[61]),
    .rdInUse(rdEnt[60]), .rdAsid(rdEnt[59:44]), .rdGpa(rdEnt[43:4]),
    .rdPerm(rdEnt[3:0]), .tblWe, .wrAssigned(wrA), .wrValidated(wrV),
    .wrImmutable(wrI), .wrSize(wrS), .wrAsid, .wrGpa, .wrPerm
  );
  poc_table_model #(.LAT(3)) mdl
  (
    .mclk, .tblRdReq, .tblIdx, .tblWe, .wrEnt, .tblRdValid, .rdEnt
  );
  initial forever #10 mclk = ~mclk;
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [64:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 4000)
    begin
      err_count++;
      $display("[FAIL] timeout");
      print_verdict();
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge mclk);
    while (wb_ack_o !== 1'b1 && ++n < 4000);
    tmo(n);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  // f is {a/d update, map, guest, protected, enc, paging ok}
  task automatic ex(input string nm, input logic [2:0] op,
                    input logic [1:0] kd, input logic [6:0] f,
                    input logic [31:0] ix, input logic [2:0] ec,
                    input logic [63:0] ek, m);
    int n = 0;
    @(posedge mclk);
    reqValid <= 1'b1;
    reqOp <= op;
    reqKind <= kd;
    {reqAdUpdate, reqMap, reqGuest, reqProtGuest, reqEncBit,
     reqPagingOk} <= f;
    reqIdx <= ix;
    do
      @(posedge mclk);
    while (reqReady !== 1'b1 && ++n < 4000);
    reqValid <= 1'b0;
    do
      @(posedge mclk);
    while (rspValid !== 1'b1 && ++n < 4000);
    tmo(n);
    chk({nm, " class"}, ec, rspClass);
    chk({nm, " code"}, ek, rspCode & m);
  endtask
  task automatic s_regs();
    rd("ctrl", REG_CTRL, 32'h0);
    rd("hole", 8'h20, 32'h0);
    wr(REG_CTRL, 32'h1);
    wr(REG_TEND, 32'h8);
    wr(REG_ADDRESS_SPACE_IDENTIFIER, 32'h5);
    wr(REG_TIER, 32'h0);
  endtask
  task automatic s_host();
    mdl.mem[2] = {5'h10, 60'h0};
    mdl.mem[9] = {5'h10, 60'h0};
    mdl.mem[5] = {5'h01, 60'h0};
    ex("hw", OP_ACCESS, ACC_WRITE, 6'h01, 32'h2, RES_PAGE_FAULT, B31, '1);
    ex("h1g", OP_ACCESS, ACC_WRITE, 6'h21, 32'h0, RES_PAGE_FAULT, B31, '1);
    ex("unc", OP_ACCESS, ACC_WRITE, 6'h01, 32'h9, RES_PASS, 0, '1);
    ex("ug", OP_ACCESS, ACC_TABLE, 6'h09, 32'h2, RES_NESTED_EXIT, B31, B31);
    ex("pg", OP_ACCESS, ACC_WRITE, 6'h00, 32'h2, RES_PASS, 0, '1);
    ex("use", OP_ACCESS, ACC_WRITE, 6'h01, 32'h5, RES_PAGE_FAULT, B31, '1);
    ex("ad", OP_ACCESS, ACC_READ, 7'h51, 32'h2, RES_PAGE_FAULT, B31, '1);
    ex("ad4", OP_ACCESS, ACC_WRITE, 7'h51, 32'h1, RES_PASS, 0, '1);
  endtask
  task automatic s_guest();
    mdl.mem[3] = {5'h10, OK1[59:0]};
    ex("vc", OP_ACCESS, ACC_WRITE, 6'h0F, 32'h3, RES_VALIDATION, 64'h404, '1);
    rd("fa_lo", REG_FADDR_LO, 32'h0000_1000);
    rd("fa_hi", REG_FADDR_HI, 32'hDEAD_BEEF);
    mdl.mem[3] = {5'h12, OK1[59:0]};
    ex("sz", OP_ACCESS, ACC_WRITE, 6'h0F, 32'h3, 2, B31 | B34, '1);
    mdl.mem[3] = {OK1[64:4], 4'hD};
    ex("tr", OP_ACCESS, ACC_WRITE, 6'h0F, 32'h3, 2, B31 | B34 | B36, '1);
    mdl.mem[3] = {5'h18, 16'h0006, OK1[43:0]};
    ex("as", OP_ACCESS, ACC_FETCH, 6'h0D, 32'h3, 2, B31 | B34, '1);
    ex("e0", OP_ACCESS, ACC_WRITE, 6'h0D, 32'h3, 2, B31, '1);
    mdl.mem[3] = {5'h10, OK1[59:0]};
    wr(REG_CTRL, 32'h3);
    wr(REG_BOUND, 32'h200);
    ex("bd", OP_ACCESS, ACC_WRITE, 6'h0D, 32'h3, RES_VALIDATION, 64'h404, '1);
    wr(REG_CTRL, 32'h1);
  endtask
  task automatic s_ops();
    mdl.mem[6] = {5'h1A, OK1[59:0]};
    mdl.mem[7] = OK1;
    mdl.mem[4] = OK1;
    mdl.mem[0] = {5'h1A, 16'h0005, 40'h100, 4'hF};
    ex("a4", OP_ACCEPT4K, ACC_WRITE, 6'h0F, 32'h6, 2, B35, B35);
    ex("a2", OP_ACCEPT2M, ACC_WRITE, 6'h0F, 32'h7, RES_SIZE_STATUS, 0, '1);
    ex("up", OP_UPDATE, ACC_WRITE, 6'h01, 32'h4, RES_PASS, 0, '1);
    // the last table write lands one edge after the edge that raises the result
    @(posedge mclk);
    chk("upval", 0, mdl.mem[4][63]);
    ex("sp", OP_SPLIT, ACC_WRITE, 6'h01, 32'h0, RES_PASS, 0, '1);
    @(posedge mclk);
    chk("split", {5'h18, 16'h0005, 40'h2FF, 4'hF}, mdl.mem[15]);
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    s_regs();
    s_host();
    s_guest();
    s_ops();
    print_verdict();
  end
endmodule
